// [hdl/aleo_exec.sv]
// execution unit: external loads, multiply, no-operation and immediate or
// --------------------------------------------------------------------------
// Summary of operation
// (RULE1) pointer load: read memory at data_pointer
// (RULE2) index load: address from index register r
// (RULE3) index load updates parity flag only
// (RULE4) multiply acc by b, overflow on product
// (RULE5) no_operation changes nothing
// (RULE6) or immediate second byte into accumulator
// (RULE7) or result to acc, parity only
// (RULE8) or immediate: two bytes, one cycle; here it takes two cycles, one per byte
// (RULE9) index register from selected bank
// --------------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
module aleo_exec
   import aleo_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   // instruction byte stream
   input  wire logic [7:0]  code_byte,
   input  wire logic        code_valid,
   output logic             code_ready,
   // index registers r0/r1 of all four banks, bank*2+r
   input  wire logic [63:0] bank_regs,
   input  wire logic [7:0]  b_load,
   input  wire logic        b_load_en,
   input  wire logic [15:0] data_pointer_load,
   input  wire logic        data_pointer_load_en,
   input  wire logic [7:0]  psw_load,
   input  wire logic        psw_load_en,
   // external data memory read
   output logic             xmem_rd,
   output logic      [15:0] xmem_addr,
   input  wire logic [7:0]  xmem_data,
   // architectural state
   output logic      [7:0]  acc_out,
   output logic      [7:0]  b_out,
   output logic      [7:0]  psw_out,
   output logic      [15:0] data_pointer_out,
   output logic             instr_done
);
   aleo_state_t state_reg;
   logic [7:0]  acc_reg, b_reg, psw_reg, opcode_reg;
   logic [15:0] data_pointer_reg, xaddr_reg;
   logic        xrd_reg, done_reg, idx_load_reg;
   logic [7:0]  or_result, mul_low, mul_high;
   logic        mul_ovf;

   // --------------------------------------------------------------------
   // helpers
   // --------------------------------------------------------------------
   function automatic logic parity_of(input logic [7:0] v);
      parity_of = ^v;
   endfunction

   function automatic logic [7:0] idx_reg(input logic [63:0] regs,
                                          input logic [7:0] program_status_word, input logic r);
      logic [2:0] sel;
      sel = {program_status_word[PSW_BANK_HIGH_BIT], program_status_word[PSW_BANK_LOW_BIT], r};   // RULE9
      idx_reg = regs[8*sel +: 8];
   endfunction

   // --------------------------------------------------------------------
   // datapath
   // --------------------------------------------------------------------
   // the alu is purely combinational, so the or result is ready in the
   // cycle the operand byte arrives; that is what keeps the or to two cycles, one per byte
   aleo_alu u_alu (
      .acc       (acc_reg),
      .b_val     (b_reg),
      .imm       (code_byte),
      .or_result (or_result),
      .mul_low   (mul_low),
      .mul_high  (mul_high),
      .mul_ovf   (mul_ovf)
   );

   // --------------------------------------------------------------------
   // byte stream handshake
   // --------------------------------------------------------------------
   // code bytes are only consumed while fetching an opcode or waiting for an operand
   assign code_ready = (state_reg == ALEO_FETCH) || (state_reg == ALEO_OPERAND);

   // --------------------------------------------------------------------
   // sequencer
   // --------------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg  <= ALEO_FETCH;
         opcode_reg <= 8'h00;
      end else begin
         case (state_reg)
            ALEO_FETCH: begin
               if (code_valid) begin
                  opcode_reg <= code_byte;
                  if (code_byte == OP_OR_IMM) begin
                     state_reg <= ALEO_OPERAND;                      // RULE8
                  end else if (code_byte == OP_LOAD_PTR ||
                               code_byte[7:1] == OP_LOAD_IDX) begin
                     state_reg <= ALEO_XREQ;
                  end else if (code_byte == OP_MUL) begin
                     state_reg <= ALEO_MULW;
                  end
               end
            end
            ALEO_OPERAND: begin
               if (code_valid) begin
                  state_reg <= ALEO_FETCH;                           // RULE8
               end
            end
            ALEO_XREQ: state_reg <= ALEO_XWAIT;
            ALEO_XWAIT: state_reg <= ALEO_FETCH;
            ALEO_MULW: state_reg <= ALEO_FETCH;
            default: state_reg <= ALEO_FETCH;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // external read request
   // --------------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         xrd_reg      <= 1'b0;
         xaddr_reg    <= 16'h0000;
         idx_load_reg <= 1'b0;
      end else if (state_reg == ALEO_XREQ) begin
         xrd_reg <= 1'b1;
         if (opcode_reg == OP_LOAD_PTR) begin
            xaddr_reg    <= data_pointer_reg;                        // RULE1
            idx_load_reg <= 1'b0;
         end else begin
            xaddr_reg    <= {8'h00, idx_reg(bank_regs, psw_reg, opcode_reg[0])}; // RULE2
            idx_load_reg <= 1'b1;
         end
      end else begin
         xrd_reg <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // accumulator
   // --------------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         acc_reg <= ACC_RESET;
      end else if (state_reg == ALEO_XWAIT) begin
         acc_reg <= xmem_data;                                       // RULE1 RULE2
      end else if (state_reg == ALEO_OPERAND && code_valid) begin
         acc_reg <= or_result;                                       // RULE7
      end else if (state_reg == ALEO_MULW) begin
         acc_reg <= mul_low;                                         // RULE4
      end
      // no_operation falls through every branch and leaves state alone  RULE5
   end

   // --------------------------------------------------------------------
   // b register
   // --------------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         b_reg <= B_RESET;
      end else if (state_reg == ALEO_MULW) begin
         b_reg <= mul_high;                                          // RULE4
      end else if (b_load_en) begin
         b_reg <= b_load;
      end
   end

   // --------------------------------------------------------------------
   // data pointer
   // --------------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         data_pointer_reg <= DATA_POINTER_RESET;
      end else if (data_pointer_load_en) begin
         data_pointer_reg <= data_pointer_load;
      end
   end

   // --------------------------------------------------------------------
   // program status word: only parity, overflow and carry move here, besides a whole-word psw_load
   // --------------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         psw_reg <= PSW_RESET;
      end else if (state_reg == ALEO_XWAIT) begin
         // pointer loads keep the flag in step too, since parity tracks acc
         psw_reg[PSW_P_BIT] <= parity_of(xmem_data);                 // RULE3
      end else if (state_reg == ALEO_OPERAND && code_valid) begin
         psw_reg[PSW_P_BIT] <= parity_of(or_result);                 // RULE7
      end else if (state_reg == ALEO_MULW) begin
         psw_reg[PSW_OVERFLOW_BIT] <= mul_ovf;                       // RULE4
         psw_reg[PSW_C_BIT]  <= 1'b0;
         psw_reg[PSW_P_BIT]  <= parity_of(mul_low);
      end else if (psw_load_en) begin
         psw_reg <= psw_load;
      end
   end

   // --------------------------------------------------------------------
   // completion pulse
   // --------------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         done_reg <= 1'b0;
      end else begin
         done_reg <= (state_reg == ALEO_XWAIT) || (state_reg == ALEO_MULW) ||
                     (state_reg == ALEO_OPERAND && code_valid) ||
                     (state_reg == ALEO_FETCH && code_valid &&
                      code_byte != OP_OR_IMM && code_byte != OP_LOAD_PTR &&
                      code_byte[7:1] != OP_LOAD_IDX && code_byte != OP_MUL);  // RULE5
      end
   end

   assign xmem_rd    = xrd_reg;
   assign xmem_addr  = xaddr_reg;
   assign acc_out    = acc_reg;
   assign b_out      = b_reg;
   assign psw_out    = psw_reg;
   assign data_pointer_out = data_pointer_reg;
   assign instr_done = done_reg;
endmodule
`default_nettype wire

// [hdl/aleo_pkg.sv]
// package: opcodes, flag positions, reset values and sequencing for the accumulator execution unit
package aleo_pkg;
   // opcodes of the instructions handled by this unit
   localparam logic [7:0] OP_LOAD_PTR   = 8'hE0;
   localparam logic [6:0] OP_LOAD_IDX   = 7'h71;   // 1110001r
   localparam logic [7:0] OP_MUL        = 8'hA4;
   localparam logic [7:0] OP_NOP        = 8'h00;
   localparam logic [7:0] OP_OR_IMM     = 8'h44;
   // program status word field positions
   localparam int PSW_P_BIT         = 0;
   localparam int PSW_OVERFLOW_BIT  = 2;
   localparam int PSW_BANK_LOW_BIT  = 3;
   localparam int PSW_BANK_HIGH_BIT = 4;
   localparam int PSW_C_BIT         = 7;
   // reset values
   localparam logic [7:0]  ACC_RESET          = 8'h00;
   localparam logic [7:0]  B_RESET            = 8'h00;
   localparam logic [7:0]  PSW_RESET          = 8'h00;
   localparam logic [15:0] DATA_POINTER_RESET = 16'h0000;
   // cycle counts of the external load (request phase + data phase)
   localparam logic [1:0] XLOAD_CYCLES = 2'h2;
   typedef enum logic [2:0] {ALEO_FETCH, ALEO_OPERAND, ALEO_XREQ, ALEO_XWAIT,
                             ALEO_MULW} aleo_state_t;
endpackage

// [hdl/aleo_alu.sv]
// combinational arithmetic/logic datapath for the execution unit
`timescale 1ns/100ps
`default_nettype none
module aleo_alu
   import aleo_pkg::*;
(
   input  wire logic [7:0]  acc,
   input  wire logic [7:0]  b_val,
   input  wire logic [7:0]  imm,
   output logic      [7:0]  or_result,
   output logic      [7:0]  mul_low,
   output logic      [7:0]  mul_high,
   output logic             mul_ovf
);
   logic [15:0] product;

   always_comb begin
      or_result = acc | imm;                          // RULE6
      product   = 16'(acc) * 16'(b_val);              // RULE4
      mul_low   = product[7:0];
      mul_high  = product[15:8];
      mul_ovf   = (product[15:8] != 8'h00);           // RULE4
   end
endmodule
`default_nettype wire

// [sim/aleo_exec_checker.sv]
// checker: port assertions for the execution unit
`timescale 1ns/100ps
`default_nettype none
module aleo_exec_checker
   import aleo_pkg::*;
(
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic [7:0]  code_byte,
   input wire logic        code_valid,
   input wire logic        code_ready,
   input wire logic [63:0] bank_regs,
   input wire logic        xmem_rd,
   input wire logic [15:0] xmem_addr,
   input wire logic [7:0]  xmem_data,
   input wire logic [7:0]  acc_out,
   input wire logic [7:0]  b_out,
   input wire logic [7:0]  psw_out,
   input wire logic [15:0] data_pointer_out,
   input wire logic        instr_done
);
   logic            opnd_reg;
   wire logic       take = code_valid && code_ready && !opnd_reg;
   wire logic       opnd = code_valid && code_ready && opnd_reg;
   wire logic [7:0] idx_val = bank_regs[{psw_out[4:3], code_byte[0], 3'b000} +: 8];
   // ---
   // the byte after an or opcode is data, not an opcode
   // ---
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         opnd_reg <= 1'b0;
      end else if (code_valid && code_ready) begin
         opnd_reg <= !opnd_reg && code_byte == OP_OR_IMM;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   sequence s_mul_res;
      {b_out, acc_out} == $past(acc_out, 2) * $past(b_out, 2)
         && psw_out[PSW_OVERFLOW_BIT] == (b_out != 8'h00) && instr_done;
   endsequence
   // the read request is registered in the cycle after the opcode, so it shows two edges on
   chk_ptr_addr: assert property (take && code_byte == OP_LOAD_PTR |=> ##1
      xmem_rd && xmem_addr == $past(data_pointer_out)) else $error("pointer load address wrong");
   chk_idx_addr: assert property (take && code_byte[7:1] == OP_LOAD_IDX |=> ##1
      xmem_rd && xmem_addr == {8'h00, $past(idx_val, 2)}) else $error("index address wrong");
   chk_load_acc: assert property (xmem_rd |=> acc_out == $past(xmem_data) && instr_done)
      else $error("loaded byte not in accumulator");
   chk_load_flags: assert property (xmem_rd |=> psw_out == {$past(psw_out[7:1]), ^acc_out})
      else $error("load flags wrong");
   chk_mul_prod: assert property (take && code_byte == OP_MUL |=> !code_ready ##1 s_mul_res)
      else $error("multiply result wrong");
   chk_nop_keep: assert property (take && code_byte == OP_NOP |=> $stable(acc_out)
      && $stable(psw_out) && $stable(b_out) && instr_done) else $error("no-op changed state");
   chk_or_acc: assert property (opnd |=> acc_out == ($past(acc_out) | $past(code_byte)))
      else $error("or result wrong");
   chk_or_flags: assert property (opnd |=> psw_out == {$past(psw_out[7:1]), ^acc_out})
      else $error("or flags wrong");
   chk_or_wait: assert property (take && code_byte == OP_OR_IMM |=> code_ready && !instr_done)
      else $error("or opcode did not wait for operand");
endmodule
bind aleo_exec aleo_exec_checker u_chk (.mclk, .arst_n, .code_byte, .code_valid, .code_ready,
   .bank_regs, .xmem_rd, .xmem_addr, .xmem_data, .acc_out, .b_out, .psw_out, .data_pointer_out,
   .instr_done);
`default_nettype wire

// [sim/aleo_xmem_model.sv]
// external data memory model: answers reads in the request cycle
`timescale 1ns/100ps
`default_nettype none
module aleo_xmem_model
(
   input wire logic        mclk,
   input wire logic        xmem_rd,
   input wire logic [15:0] xmem_addr,
   output logic     [7:0]  xmem_data
);
   logic [7:0] last_reg = 8'h00;
   always @(posedge mclk) if (xmem_rd) last_reg <= xmem_data;
   // idle bus shows inverted data so a late sample cannot pass
   assign xmem_data = xmem_rd ? xmem_addr[7:0] ^ xmem_addr[15:8] ^ 8'h3C : ~last_reg;
endmodule
`default_nettype wire

// [sim/tb_aleo_exec.sv]
// testbench: directed scenarios for the execution unit
`timescale 1ns/100ps
`default_nettype none
module tb_aleo_exec
   import aleo_pkg::*;
;
   logic        mclk, arst_n, code_valid, code_ready, b_load_en, psw_load_en;
   logic        data_pointer_load_en, xmem_rd, instr_done;
   logic [7:0]  code_byte, b_load, psw_load, xmem_data, acc_out, b_out, psw_out, ea, eb, ep;
   logic [15:0] data_pointer_load, xmem_addr, data_pointer_out, ed;
   logic [63:0] bank_regs;
   int          failures, checks, cyc;
   aleo_exec dut (.mclk, .arst_n, .code_byte, .code_valid, .code_ready, .bank_regs, .b_load,
      .b_load_en, .data_pointer_load, .data_pointer_load_en, .psw_load, .psw_load_en, .xmem_rd,
      .xmem_addr, .xmem_data, .acc_out, .b_out, .psw_out, .data_pointer_out, .instr_done);
   aleo_xmem_model mem (.mclk, .xmem_rd, .xmem_addr, .xmem_data);
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 2000) begin
         failures++;
         close_out();
      end
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task close_out;
      if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // valid stays high on return; the caller drops it
   task automatic send(input logic [7:0] b);
      code_byte = b;
      code_valid = 1'b1;
      while (code_ready !== 1'b1) @(posedge mclk) #2;
      @(posedge mclk) #2;
   endtask
   task automatic side(input logic [7:0] b, input logic [15:0] d, input logic [7:0] p);
      {b_load, data_pointer_load, psw_load} = {b, d, p[7:1], ^ea};
      {b_load_en, data_pointer_load_en, psw_load_en} = 3'h7;
      @(posedge mclk) #2;
      {b_load_en, data_pointer_load_en, psw_load_en} = 3'h0;
      {eb, ed, ep} = {b, d, psw_load};
   endtask
   // the request goes out one edge after the opcode, the byte lands one edge later
   task automatic ld(input logic [7:0] op, input logic [15:0] a);
      send(op);
      code_valid = 1'b0;
      @(posedge mclk) #2;
      chk(16'(xmem_rd), 16'h0001);
      chk(xmem_addr, a);
      @(posedge mclk) #2;
      ea = a[7:0] ^ a[15:8] ^ 8'h3C;
      ep[PSW_P_BIT] = ^ea;
      chk(16'(acc_out), 16'(ea));
      chk(16'(psw_out), 16'(ep));
      chk(16'(instr_done), 16'h0001);
      chk(16'(xmem_rd), 16'h0000);
      chk(data_pointer_out, ed);
   endtask
   task automatic mul();
      send(OP_MUL);
      code_valid = 1'b0;
      @(posedge mclk) #2;
      {eb, ea} = 16'(ea) * 16'(eb);
      {ep[PSW_C_BIT], ep[PSW_OVERFLOW_BIT], ep[PSW_P_BIT]} = {1'b0, eb != 8'h00, ^ea};
      chk({b_out, acc_out}, {eb, ea});
      chk(16'(psw_out), 16'(ep));
      chk(16'(instr_done), 16'h0001);
   endtask
   task automatic orim(input logic [7:0] imm);
      send(OP_OR_IMM);
      chk(16'(instr_done), 16'h0000);
      send(imm);
      code_valid = 1'b0;
      ea = ea | imm;
      ep[PSW_P_BIT] = ^ea;
      chk(16'(acc_out), 16'(ea));
      chk(16'(psw_out), 16'(ep));
      chk(16'(instr_done), 16'h0001);
   endtask
   task automatic no_operation();
      send(OP_NOP);
      code_valid = 1'b0;
      chk(16'(instr_done), 16'h0001);
      chk({psw_out, acc_out}, {ep, ea});
      chk(16'(b_out), 16'(eb));
   endtask
   initial begin
      {code_valid, b_load_en, data_pointer_load_en, psw_load_en, arst_n} = 5'h00;
      {code_byte, b_load, psw_load, ea, eb, ep, data_pointer_load} = 64'h0;
      bank_regs = 64'hF1E2D3C4B5A69788;
      {failures, checks, cyc} = 96'h0;
      repeat (3) @(posedge mclk);
      #2 arst_n = 1'b1;
      chk({7'h00, code_ready, acc_out}, 16'h0100);
      side(8'h03, 16'hA512, 8'h84);
      ld(OP_LOAD_PTR, 16'hA512);
      for (int i = 0; i < 8; i++) begin
         side(8'h01, ed, {3'b100, i[2:1], 3'b100});
         ld({OP_LOAD_IDX, i[0]}, {8'h00, bank_regs[i*8 +: 8]});
      end
      mul();
      side(8'hFF, ed, 8'h04);
      mul();
      orim(8'h5F);
      no_operation();
      close_out();
   end
endmodule
`default_nettype wire
